// ### bench/dram_model.sv
// behavioural model of the page-mode dram
`default_nettype none
module dram_model (
  input wire logic [8:0] multiplexed_address_pins,
  input wire logic row_strobe_n,
  input wire logic lower_byte_column_strobe_n,
  input wire logic upper_byte_column_strobe_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output var int ras_falls,
  output var int cbr_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // ***********
  // array model
  // ***********
  logic [15:0] mem [0:262143];
  logic [8:0] row_r, col_r, cnt_r;
  logic acc_ok;
  wire logic lo_n = lower_byte_column_strobe_n;
  wire logic up_n = upper_byte_column_strobe_n;
  wire logic cas_n = lo_n && up_n;
  wire logic [17:0] key = {row_r, col_r};
  wire logic rd_on = acc_ok && !output_enable_n && write_enable_n;
  // released lane shows the inverse
  assign dq_out[7:0] = (rd_on && !lo_n) ? mem[key][7:0] : ~mem[key][7:0];
  assign dq_out[15:8] = (rd_on && !up_n) ? mem[key][15:8] : ~mem[key][15:8];
  initial begin
    ras_falls = 0;
    cbr_count = 0;
    cnt_r = 9'h000;
    acc_ok = 1'h0;
  end
  always @(negedge row_strobe_n) begin
    ras_falls <= ras_falls + 1;
    if (!cas_n) begin
      cbr_count <= cbr_count + 1;
      cnt_r <= cnt_r + 9'h001;
    end else begin
      row_r <= multiplexed_address_pins;
    end
  end
  always @(negedge cas_n) begin
    col_r <= multiplexed_address_pins;
    acc_ok <= !row_strobe_n;
  end
  always @(posedge cas_n) acc_ok <= 1'h0;
  always @(negedge lo_n or negedge up_n or negedge write_enable_n) begin
    #1;
    if (!row_strobe_n && !write_enable_n && acc_ok) begin
      if (!lo_n) mem[key][7:0] = dq_in[7:0];
      if (!up_n) mem[key][15:8] = dq_in[15:8];
    end
  end
endmodule : dram_model
`default_nettype wire

// ### bench/dram_page_asserts.sv
// pin-level assertions for the dram controller
`default_nettype none
module dram_page_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req_ready,
  input wire logic init_done,
  input wire logic row_strobe_n,
  input wire logic lower_byte_column_strobe_n,
  input wire logic upper_byte_column_strobe_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic [1:0] bidirectional_data_pins_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************
  // strobe rules
  // ************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic all_high = row_strobe_n && lower_byte_column_strobe_n
    && upper_byte_column_strobe_n;
  sequence ras_held; !row_strobe_n [*3]; endsequence
  sequence ras_rest; row_strobe_n [*2]; endsequence
  reset_idle_a: assert property (disable iff (1'h0)
    reset |=> all_high && bidirectional_data_pins_oe == 2'h0)
    else $error("strobes not idle after reset");
  ras_active_a: assert property ($fell(row_strobe_n) |-> ras_held)
    else $error("row strobe active too short");
  ras_rest_a: assert property ($rose(row_strobe_n) |-> ras_rest)
    else $error("row precharge too short");
  row_cycle_a: assert property (
    $fell(row_strobe_n) |=> (!$fell(row_strobe_n)) [*4])
    else $error("row cycles too close");
  col_row_a: assert property (
    $fell(lower_byte_column_strobe_n) && !row_strobe_n
    |-> !$past(row_strobe_n)) else $error("column before row address");
  read_we_a: assert property (
    !output_enable_n |-> write_enable_n) else $error("read with we low");
  read_free_a: assert property (
    !output_enable_n |-> bidirectional_data_pins_oe == 2'h0)
    else $error("controller drives during read");
  write_lane_a: assert property (
    !write_enable_n && !lower_byte_column_strobe_n && !row_strobe_n
    |-> bidirectional_data_pins_oe[0]) else $error("write lane undriven");
  init_gate_a: assert property (
    !init_done |-> !req_ready) else $error("ready before wake-up");
  ready_idle_a: assert property (
    req_ready |-> all_high) else $error("ready inside a cycle");
endmodule : dram_page_asserts
bind dram_page_controller dram_page_asserts chk (.sys_clk, .reset,
  .req_ready, .init_done, .row_strobe_n, .lower_byte_column_strobe_n,
  .upper_byte_column_strobe_n, .write_enable_n, .output_enable_n,
  .bidirectional_data_pins_oe);
`default_nettype wire

// ### bench/tb.sv
// testbench for the page-mode dram controller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // *******
  // harness
  // *******
  localparam int PWR = 20;
  localparam int GAP = 50;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic req_valid = 1'h0;
  logic [1:0] req_cmd = 2'h0;
  logic [17:0] req_addr = 18'h0_0000;
  logic [1:0] req_byte_en = 2'h3;
  logic [15:0] req_wdata = 16'h0000;
  logic req_hidden_refresh = 1'h0;
  logic refresh_overdue = 1'h0;
  logic req_ready, rsp_valid, init_done, row_strobe_n, write_enable_n;
  logic lower_byte_column_strobe_n, upper_byte_column_strobe_n;
  logic output_enable_n;
  logic [15:0] rsp_rdata, bidirectional_data_pins_o, dq_out, d;
  logic [15:0] bidirectional_data_pins_i;
  logic [8:0] multiplexed_address_pins;
  logic [1:0] bidirectional_data_pins_oe;
  int ras_falls, cbr_count, f0;
  int fail_count = 0;
  int checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  assign bidirectional_data_pins_i = {
    bidirectional_data_pins_oe[1] ? bidirectional_data_pins_o[15:8]
      : dq_out[15:8],
    bidirectional_data_pins_oe[0] ? bidirectional_data_pins_o[7:0]
      : dq_out[7:0]};
  dram_page_controller #(.POWER_UP_CYCLES(PWR), .REFRESH_GAP(GAP)) DUT (
    .sys_clk, .reset, .req_valid, .req_cmd, .req_addr, .req_byte_en,
    .req_wdata, .req_hidden_refresh, .refresh_overdue, .req_ready,
    .rsp_valid, .rsp_rdata, .init_done, .multiplexed_address_pins,
    .row_strobe_n, .lower_byte_column_strobe_n, .upper_byte_column_strobe_n,
    .write_enable_n, .output_enable_n, .bidirectional_data_pins_i,
    .bidirectional_data_pins_o, .bidirectional_data_pins_oe);
  dram_model mem_u (.multiplexed_address_pins, .row_strobe_n,
    .lower_byte_column_strobe_n, .upper_byte_column_strobe_n,
    .write_enable_n, .output_enable_n, .dq_in(bidirectional_data_pins_i),
    .dq_out, .ras_falls, .cbr_count);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic lost();
    fail_count++;
    close_out();
  endtask : lost
  task automatic xfer(input logic [1:0] cmd, input logic [17:0] a,
      input logic [1:0] be, input logic [15:0] wd, input logic hid);
    int n;
    n = 0;
    @(posedge sys_clk);
    #2;
    req_valid = 1'h1;
    req_cmd = cmd;
    req_addr = a;
    req_byte_en = be;
    req_wdata = wd;
    req_hidden_refresh = hid;
    while (!req_ready && n < 500) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    if (n >= 500) lost();
    @(posedge sys_clk);
    #2;
    req_valid = 1'h0;
    n = 0;
    if (cmd != dram_port_pkg::CMD_WRITE) begin
      do begin
        @(posedge sys_clk);
        #1;
        n++;
      end while (!rsp_valid && n < 60);
      if (n >= 60) lost();
      d = rsp_rdata;
    end
    // let the late write of a write or rmw land in the model
    repeat (6) @(posedge sys_clk);
    #1;
  endtask : xfer
  // *********
  // scenarios
  // *********
  task automatic t_power();
    int n;
    n = 0;
    repeat (PWR - 1) @(posedge sys_clk);
    check(ras_falls, 0);
    while (!init_done && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 2000) lost();
    check(ras_falls >= 8, 1);
    $display("done power_up");
  endtask : t_power
  task automatic t_word();
    xfer(dram_port_pkg::CMD_WRITE, 18'h2_a5c3, 2'h3, 16'hbeef, 1'h0);
    check(mem_u.mem[18'h2_a5c3], 16'hbeef);
    xfer(dram_port_pkg::CMD_READ, 18'h2_a5c3, 2'h3, 16'h0000, 1'h0);
    check(d, 16'hbeef);
    $display("done word");
  endtask : t_word
  task automatic t_bytes();
    xfer(dram_port_pkg::CMD_WRITE, 18'h1_5a3c, 2'h3, 16'h1111, 1'h0);
    xfer(dram_port_pkg::CMD_WRITE, 18'h1_5a3c, 2'h1, 16'h22aa, 1'h0);
    xfer(dram_port_pkg::CMD_WRITE, 18'h1_5a3c, 2'h2, 16'hcc33, 1'h0);
    xfer(dram_port_pkg::CMD_READ, 18'h1_5a3c, 2'h3, 16'h0000, 1'h0);
    check(d, 16'hccaa);
    xfer(dram_port_pkg::CMD_READ, 18'h1_5a3c, 2'h2, 16'h0000, 1'h0);
    check(d[15:8], 8'hcc);
    xfer(dram_port_pkg::CMD_RMW, 18'h1_5a3c, 2'h3, 16'h5678, 1'h0);
    check(d, 16'hccaa);
    check(mem_u.mem[18'h1_5a3c], 16'h5678);
    $display("done bytes_rmw");
  endtask : t_bytes
  task automatic t_refresh();
    f0 = cbr_count;
    xfer(dram_port_pkg::CMD_READ, 18'h2_a5c3, 2'h3, 16'h0000, 1'h1);
    check(d, 16'hbeef);
    check(cbr_count > f0, 1);
    f0 = cbr_count;
    repeat (2 * GAP) @(posedge sys_clk);
    check(cbr_count - f0 >= 1, 1);
    f0 = ras_falls;
    @(posedge sys_clk);
    #2;
    refresh_overdue = 1'h1;
    @(posedge sys_clk);
    #2;
    refresh_overdue = 1'h0;
    xfer(dram_port_pkg::CMD_READ, 18'h2_a5c3, 2'h3, 16'h0000, 1'h0);
    check(ras_falls - f0 >= 9, 1);
    check(d, 16'hbeef);
    $display("done refresh");
  endtask : t_refresh
  initial begin
    repeat (12) @(posedge sys_clk);
    #2;
    reset = 1'h0;
    t_power();
    t_word();
    t_bytes();
    t_refresh();
    close_out();
  end
  initial begin
    #500000;
    lost();
  end
endmodule : tb
`default_nettype wire

// ### hdl/cycle_timer.sv
// down counter that flags when a loaded wait has elapsed
`default_nettype none
module cycle_timer (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [dram_port_pkg::TIMER_BITS-1:0] count,
  output logic done
);
  logic [dram_port_pkg::TIMER_BITS-1:0] cnt_r;
  wire logic [dram_port_pkg::TIMER_BITS-1:0] cnt_nxt =
    load ? count :
    (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
  // done must not look at load: callers load on done in the same cycle
  assign done = (cnt_r == '0);
  // load wins over reset so the power-up wait starts at release
  always_ff @(posedge sys_clk) begin
    if (reset && !load) cnt_r <= '0;
    else cnt_r <= cnt_nxt;
  end
endmodule : cycle_timer
`default_nettype wire

// ### hdl/dram_page_controller.sv
// controller driving a page-mode dram through its pins
`default_nettype none
module dram_page_controller #(
  parameter int POWER_UP_CYCLES = dram_port_pkg::POWER_UP_CYC,
  parameter int REFRESH_GAP = dram_port_pkg::REFRESH_GAP_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic [1:0] req_cmd,
  input wire logic [dram_port_pkg::ADDR_BITS-1:0] req_addr,
  input wire logic [1:0] req_byte_en,
  input wire logic [dram_port_pkg::DATA_BITS-1:0] req_wdata,
  input wire logic req_hidden_refresh,
  input wire logic refresh_overdue,
  output logic req_ready,
  output logic rsp_valid,
  output logic [dram_port_pkg::DATA_BITS-1:0] rsp_rdata,
  output logic init_done,
  output logic [dram_port_pkg::ROW_BITS-1:0] multiplexed_address_pins,
  output logic row_strobe_n,
  output logic lower_byte_column_strobe_n,
  output logic upper_byte_column_strobe_n,
  output logic write_enable_n,
  output logic output_enable_n,
  input wire logic [dram_port_pkg::DATA_BITS-1:0] bidirectional_data_pins_i,
  output logic [dram_port_pkg::DATA_BITS-1:0] bidirectional_data_pins_o,
  output logic [1:0] bidirectional_data_pins_oe
);
  localparam int TB = dram_port_pkg::TIMER_BITS;
  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_POWER, ST_IDLE, ST_ROW, ST_COL, ST_ACCESS, ST_RMW_WRITE,
    ST_HIDDEN_UP, ST_HIDDEN_DOWN, ST_CBR_CAS, ST_CBR_RAS, ST_RELEASE,
    ST_PRECHARGE
  } state_e;
  state_e state_r, state_nxt;
  logic [TB-1:0] tload_val;
  logic tload, tdone;
  logic [3:0] wake_r;
  logic [TB-1:0] ref_cnt_r;
  logic ref_due_r;
  logic [1:0] cmd_r;
  logic [dram_port_pkg::ADDR_BITS-1:0] addr_r;
  logic [1:0] be_r;
  logic [dram_port_pkg::DATA_BITS-1:0] wdata_r;
  logic hidden_r;
  logic [dram_port_pkg::DATA_BITS-1:0] din_meta_r, din_sync_r;
  logic [2:0] ras_age_r;
  cycle_timer u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .load(tload),
    .count(tload_val),
    .done(tdone)
  );
  // ****************************************************************
  // decode
  // ****************************************************************
  wire logic need_wake = (wake_r != 4'(dram_port_pkg::WAKE_CYCLES));
  wire logic ras_min_ok =
    (ras_age_r >= 3'(dram_port_pkg::RAS_ACTIVE_CYC));
  wire logic take_ref = (ref_due_r || need_wake);
  wire logic take_req = req_valid && req_ready && !need_wake && !ref_due_r;
  wire logic ref_soon = (ref_cnt_r >= TB'(REFRESH_GAP - 1));
  wire logic is_write = (cmd_r == dram_port_pkg::CMD_WRITE);
  wire logic is_rmw = (cmd_r == dram_port_pkg::CMD_RMW);
  wire logic [dram_port_pkg::ROW_BITS-1:0] row_half =
    addr_r[dram_port_pkg::ADDR_BITS-1 -: dram_port_pkg::ROW_BITS];
  wire logic [dram_port_pkg::COL_BITS-1:0] col_half =
    addr_r[dram_port_pkg::COL_BITS-1:0];
  wire logic access_end = tdone && ras_min_ok;
  wire logic [TB-1:0] acc_wait = TB'(dram_port_pkg::ACCESS_RAS_CYC);
  wire logic [TB-1:0] pre_wait = TB'(dram_port_pkg::ROW_PRECHARGE_CYC +
    dram_port_pkg::CAS_PRECHARGE_CYC);
  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    tload = 1'b0;
    tload_val = '0;
    case (state_r)
      ST_POWER: if (tdone) state_nxt = ST_IDLE;
      ST_IDLE: begin
        if (take_ref) begin
          state_nxt = ST_CBR_CAS;
        end else if (take_req) begin
          state_nxt = ST_ROW;
        end
      end
      ST_ROW: begin
        state_nxt = ST_COL;
        tload = 1'b1;
        tload_val = TB'(dram_port_pkg::RAS_TO_CAS_CYC);
      end
      ST_COL: if (tdone) begin
        state_nxt = ST_ACCESS;
        tload = 1'b1;
        tload_val = acc_wait;
      end
      ST_ACCESS: if (access_end) begin
        if (is_rmw) begin
          state_nxt = ST_RMW_WRITE;
          tload = 1'b1;
          tload_val = TB'(dram_port_pkg::CAS_PULSE_CYC);
        end else if (hidden_r && !is_write) begin
          state_nxt = ST_HIDDEN_UP;
          tload = 1'b1;
          tload_val = TB'(dram_port_pkg::ROW_PRECHARGE_CYC);
        end else begin
          state_nxt = ST_RELEASE;
        end
      end
      ST_RMW_WRITE: if (tdone) state_nxt = ST_RELEASE;
      ST_HIDDEN_UP: if (tdone) begin
        state_nxt = ST_HIDDEN_DOWN;
        tload = 1'b1;
        tload_val = TB'(dram_port_pkg::RAS_ACTIVE_CYC);
      end
      ST_HIDDEN_DOWN: if (tdone) state_nxt = ST_RELEASE;
      ST_CBR_CAS: begin
        state_nxt = ST_CBR_RAS;
        tload = 1'b1;
        tload_val = TB'(dram_port_pkg::RAS_ACTIVE_CYC);
      end
      ST_CBR_RAS: if (tdone) state_nxt = ST_RELEASE;
      ST_RELEASE: begin
        state_nxt = ST_PRECHARGE;
        tload = 1'b1;
        tload_val = pre_wait;
      end
      ST_PRECHARGE: if (tdone) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    if (reset) begin
      tload = 1'b1;
      tload_val = TB'(POWER_UP_CYCLES);
    end
  end
  // ****************************************************************
  // pin drive
  // ****************************************************************
  wire logic ras_low = (state_r == ST_COL) || (state_r == ST_ACCESS) ||
    (state_r == ST_RMW_WRITE) || (state_r == ST_HIDDEN_DOWN) ||
    (state_r == ST_CBR_RAS);
  wire logic cas_on = (state_r == ST_ACCESS) || (state_r == ST_RMW_WRITE) ||
    (state_r == ST_HIDDEN_UP) || (state_r == ST_HIDDEN_DOWN);
  wire logic cbr_cas = (state_r == ST_CBR_CAS) ||
    (state_r == ST_CBR_RAS);
  wire logic [1:0] cas_lane = cbr_cas ? 2'h3 :
    (cas_on ? be_r : 2'h0);
  wire logic rd_phase = !is_write && !cbr_cas &&
    ((state_r == ST_ACCESS) || (state_r == ST_HIDDEN_UP) ||
    (state_r == ST_HIDDEN_DOWN));
  wire logic wr_phase = !cbr_cas && ((is_write && cas_on) ||
    (state_r == ST_RMW_WRITE));
  wire logic [dram_port_pkg::ROW_BITS-1:0] addr_nxt =
    (state_r == ST_IDLE || state_r == ST_ROW ||
    (state_r == ST_COL && !tdone)) ? row_half :
    col_half;
  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= ST_POWER;
      wake_r <= '0;
      ref_cnt_r <= '0;
      ref_due_r <= 1'b0;
      cmd_r <= dram_port_pkg::CMD_READ;
      addr_r <= '0;
      be_r <= 2'h0;
      wdata_r <= '0;
      hidden_r <= 1'b0;
      ras_age_r <= '0;
    end else begin
      state_r <= state_nxt;
      ras_age_r <= !ras_low ? 3'h0 :
        (ras_age_r != 3'h7 ? ras_age_r + 3'h1 : ras_age_r);
      if (refresh_overdue) begin
        wake_r <= '0;
      end else if (state_r == ST_CBR_RAS && tdone && need_wake) begin
        wake_r <= wake_r + 4'h1;
      end
      if (state_r == ST_CBR_RAS && tdone) begin
        ref_cnt_r <= '0;
        ref_due_r <= 1'b0;
      end else if (ref_soon) begin
        ref_due_r <= 1'b1;
      end else begin
        ref_cnt_r <= ref_cnt_r + 1'b1;
      end
      if (state_r == ST_IDLE && take_req && !take_ref) begin
        cmd_r <= req_cmd;
        addr_r <= req_addr;
        be_r <= req_byte_en;
        wdata_r <= req_wdata;
        hidden_r <= req_hidden_refresh;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      init_done <= 1'b0;
      multiplexed_address_pins <= '0;
      row_strobe_n <= 1'b1;
      lower_byte_column_strobe_n <= 1'b1;
      upper_byte_column_strobe_n <= 1'b1;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      bidirectional_data_pins_o <= '0;
      bidirectional_data_pins_oe <= 2'h0;
      din_meta_r <= '0;
      din_sync_r <= '0;
    end else begin
      din_meta_r <= bidirectional_data_pins_i;
      din_sync_r <= din_meta_r;
      // ready only when the next idle cycle will surely take a request
      req_ready <= (state_nxt == ST_IDLE) && !need_wake && !ref_due_r &&
        !ref_soon && !refresh_overdue;
      init_done <= !need_wake;
      rsp_valid <= (state_r == ST_ACCESS) && access_end && !is_write;
      if ((state_r == ST_ACCESS) && access_end)
        rsp_rdata <= din_sync_r;
      multiplexed_address_pins <= addr_nxt;
      row_strobe_n <= !ras_low;
      lower_byte_column_strobe_n <= !cas_lane[0];
      upper_byte_column_strobe_n <= !cas_lane[1];
      write_enable_n <= !wr_phase;
      output_enable_n <= !rd_phase || (state_r == ST_RMW_WRITE);
      bidirectional_data_pins_o <= wdata_r;
      bidirectional_data_pins_oe <= (wr_phase || (is_write &&
        state_r == ST_COL)) ? be_r : 2'h0;
    end
  end
endmodule : dram_page_controller
`default_nettype wire

// ### hdl/dram_port_pkg.sv
// constants for the page-mode dram controller
`default_nettype none
package dram_port_pkg;
  localparam int CLK_PERIOD_NS = 25;
  // address split
  localparam int ROW_BITS = 9;
  localparam int COL_BITS = 9;
  localparam int ADDR_BITS = 18;
  localparam int DATA_BITS = 16;
  localparam int ROWS = 512;
  // slow grade timing figures in ns, plus the wake-up refresh count
  localparam int RAS_ACTIVE_NS = 60;
  localparam int ROW_PRECHARGE_NS = 40;
  localparam int CAS_PRECHARGE_NS = 10;
  localparam int CAS_PULSE_NS = 15;
  localparam int RAS_TO_CAS_NS = 20;
  localparam int CYCLE_NS = 110;
  localparam int PAGE_CYCLE_NS = 25;
  localparam int ACCESS_RAS_NS = 60;
  localparam int REFRESH_PERIOD_NS = 8000000;
  localparam int POWER_UP_NS = 200000;
  localparam int WAKE_CYCLES = 8;
  // least times round up, refresh spacing rounds down
  localparam int RAS_ACTIVE_CYC =
    (RAS_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_PRECHARGE_CYC =
    (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_PRECHARGE_CYC =
    (CAS_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_PULSE_CYC =
    (CAS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_TO_CAS_CYC =
    (RAS_TO_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_RAS_CYC =
    (ACCESS_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_UP_CYC =
    (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_GAP_CYC =
    REFRESH_PERIOD_NS / CLK_PERIOD_NS / ROWS;
  localparam int TIMER_BITS = 16;
  // command codes
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_RMW = 2'h2;
endpackage : dram_port_pkg
`default_nettype wire
